/* common/ata_dev_map.vh */
/*
 Constants for the device-side parallel disk port: register addresses,
 control bit positions, timing figures and reset values.
 Assumes a 200 MHz core clock; included by its bare name.
*/
`ifndef ATA_DEV_MAP_VH
`define ATA_DEV_MAP_VH

// Core clock rate
`define CLK_MHZ 200

// Register addresses {cs1 selected, da[2:0]}
`define ADDR_DEV_HEAD 4'h6
`define ADDR_STAT_CMD 4'h7
`define ADDR_DEV_CTRL 4'he
`define ADDR_ALT_STAT 4'he

// Field positions
`define DEVHEAD_DEV_BIT 4
`define DEVCTRL_SRST_BIT 2
`define DEVCTRL_NIEN_BIT 1

// Reset values
`define DEV_SEL_RST 1'b0
`define NIEN_RST 1'b0
`define SRST_RST 1'b0
`define WORD_RST 16'h0000
`define ADDR_RST 4'h0

// Data-in strobe half period, least time, ns
`define DSTROBE_HALF_NS 30
`define DSTROBE_HALF_CYC (((`DSTROBE_HALF_NS * `CLK_MHZ) + 999) / 1000)
`define HALF_CNT_W 4

// Presence phase of the shared activity line, in cycles
`define DASP_PRESENCE_CYC 32'd1000000

// Burst states: idle, data-in, data-out
`define BST_IDLE 2'h0
`define BST_IN 2'h1
`define BST_OUT 2'h2

`endif

/* core/ata_device_host_signals.v */
/*
 Device end of a parallel disk interface: register strobe decode, interrupt
 line control, double-edge DMA bursts in both directions, and the
 diagnostics, cable and activity sideband lines.
 Assumes every host pin arrives asynchronously and is synchronised here;
 the drive logic behind the user-side ports runs on clk.
*/
`include "ata_dev_map.vh"

// Function
// RULE1 - Host read strobe makes device drive data
// RULE2 - Host ready line permits data-in words
// RULE3 - Host ready negated halts data-in transfers
// RULE4 - Capture data on both host strobe edges
// RULE5 - Missing host strobe edges mean pause
// RULE6 - Hardware or software reset clears interrupt
// RULE7 - Command write or status read clears interrupt
// RULE8 - Sector transfer completion clears interrupt
// RULE9 - Interrupt line floats unselected or disabled
// RULE10 - First chip select addresses command block
// RULE11 - Second chip select addresses control block
// RULE12 - Three address lines decoded with selects
// RULE13 - Diagnostics line: master input, slave output
// RULE14 - Slave asserts diagnostics line when done
// RULE15 - Cable line tells 80 or 40 conductors
// RULE16 - Activity line multiplexes presence and activity
// RULE17 - Host stop ends the burst
// RULE18 - Device makes data-in strobe, pauses by withholding
// RULE19 - Device ready asserted when data accepted
// RULE20 - Request raised when ready, dropped on acknowledge
// RULE21 - Data bus driven only when reading
module ata_device_host_signals #(
   parameter [31:0] PRESENCE_CYCLES = `DASP_PRESENCE_CYC
) (
   input wire clk,
   input wire rst,
   input wire reset_n,
   input wire csel_n,
   input wire cs0_n,
   input wire cs1_n,
   input wire [2:0] da,
   input wire dior_n,
   input wire diow_n,
   input wire dmack_n,
   input wire stop,
   input wire hdmardy_n,
   input wire hstrobe,
   input wire [15:0] dd_in,
   output reg [15:0] dd_out,
   output reg dd_oe_n,
   output reg intrq_out,
   output reg intrq_oe_n,
   output reg dmarq,
   output reg ddmardy_n,
   output reg dstrobe,
   input wire pdiag_in,
   output reg pdiag_out,
   output reg pdiag_oe_n,
   input wire cblid_in,
   output reg dasp_out,
   output reg dasp_oe_n,
   input wire [15:0] rd_data,
   output reg [3:0] acc_addr,
   output reg rd_pulse,
   output reg wr_pulse,
   output reg [15:0] wr_data,
   output reg soft_reset,
   output reg is_slave,
   output reg cable_80,
   output reg slave_passed,
   input wire irq_set,
   input wire sector_done,
   input wire diag_done,
   input wire drive_active,
   input wire dma_ready,
   input wire dma_dir_in,
   input wire [15:0] tx_data,
   input wire tx_valid,
   output reg tx_take,
   output reg [15:0] rx_data,
   output reg rx_valid,
   input wire rx_ready,
   output reg burst_end
);

   // Register decode: bit 4 valid, bits 3:0 {control block, da}
   function [4:0] reg_decode;
      input c0_n;
      input c1_n;
      input [2:0] a;
      begin
         reg_decode = {(c0_n ^ c1_n), ~c1_n, a}; // [RULE10] [RULE11] [RULE12]
      end
   endfunction

   // Two-flop synchronisers; bit order below
   localparam SW = 12;
   wire [SW-1:0] pin_raw;
   reg [SW-1:0] s1_reg;
   reg [SW-1:0] s2_reg;
   reg [SW-1:0] s3_reg;
   reg [15:0] d1_reg;
   reg [15:0] d2_reg;
   assign pin_raw = {reset_n, csel_n, cs0_n, cs1_n, da, dior_n, diow_n, dmack_n, stop,
      hdmardy_n};
   reg [2:0] sb1_reg;
   reg [2:0] sb2_reg;
   reg hs3_reg;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg <= {SW{1'b1}};
         s2_reg <= {SW{1'b1}};
         s3_reg <= {SW{1'b1}};
         d1_reg <= `WORD_RST;
         d2_reg <= `WORD_RST;
         sb1_reg <= 3'h7;
         sb2_reg <= 3'h7;
         hs3_reg <= 1'b1;
      end else begin
         s1_reg <= pin_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         d1_reg <= dd_in;
         d2_reg <= d1_reg;
         sb1_reg <= {hstrobe, pdiag_in, cblid_in};
         sb2_reg <= sb1_reg;
         hs3_reg <= sb2_reg[2];
      end
   end

   wire hw_rst_s = ~s2_reg[11];
   wire csel_s = s2_reg[10];
   wire [4:0] dec_s = reg_decode(s2_reg[9], s2_reg[8], s2_reg[7:5]);
   wire dior_s = s2_reg[4];
   wire dior_fall = s3_reg[4] & ~s2_reg[4];
   wire diow_rise = ~s3_reg[3] & s2_reg[3];
   wire dmack_s = s2_reg[2];
   wire stop_s = s2_reg[1];
   wire hdmardy_s = s2_reg[0];
   wire hs_edge = sb2_reg[2] ^ hs3_reg;
   wire pio_ok = dec_s[4] & dmack_s;
   wire rd_evt = dior_fall & pio_ok; // [RULE1]
   wire wr_evt = diow_rise & pio_ok;

   // Task file bits the port itself needs
   reg dev_sel_reg;
   reg nien_reg;
   reg srst_reg;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         dev_sel_reg <= `DEV_SEL_RST;
         nien_reg <= `NIEN_RST;
         srst_reg <= `SRST_RST;
      end else if (hw_rst_s) begin
         dev_sel_reg <= `DEV_SEL_RST;
         nien_reg <= `NIEN_RST;
         srst_reg <= `SRST_RST;
      end else if (wr_evt && dec_s[3:0] == `ADDR_DEV_HEAD) begin
         dev_sel_reg <= d2_reg[`DEVHEAD_DEV_BIT];
      end else if (wr_evt && dec_s[3:0] == `ADDR_DEV_CTRL) begin
         srst_reg <= d2_reg[`DEVCTRL_SRST_BIT];
         nien_reg <= d2_reg[`DEVCTRL_NIEN_BIT];
      end
   end

   // Interrupt pending; a new event wins over any clear
   reg pend_reg;
   // Device select bit 0 names the master, whose strap is low
   wire selected = (dev_sel_reg == csel_s);
   wire int_clr = hw_rst_s | srst_reg // [RULE6]
      | (wr_evt && dec_s[3:0] == `ADDR_STAT_CMD) // [RULE7]
      | (rd_evt && dec_s[3:0] == `ADDR_STAT_CMD) // [RULE7]
      | sector_done; // [RULE8]
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_reg <= 1'b0;
      end else if (irq_set) begin
         pend_reg <= 1'b1;
      end else if (int_clr) begin
         pend_reg <= 1'b0;
      end
   end

   // Burst engine
   reg [1:0] bst_reg;
   reg [1:0] bst_next;
   reg [`HALF_CNT_W-1:0] half_reg;
   wire in_burst = (bst_reg == `BST_IN);
   wire out_burst = (bst_reg == `BST_OUT);
   localparam [31:0] HALF_LAST = `DSTROBE_HALF_CYC - 1;
   wire half_done = (half_reg == HALF_LAST[`HALF_CNT_W-1:0]);
   wire in_step = in_burst & ~hdmardy_s & ~stop_s & tx_valid & half_done; // [RULE2] [RULE3]

   always @* begin
      bst_next = bst_reg;
      case (bst_reg)
         `BST_IDLE: begin
            if (~dmack_s && ~stop_s && dmarq) begin
               bst_next = dma_dir_in ? `BST_IN : `BST_OUT;
            end
         end
         `BST_IN, `BST_OUT: begin
            if (stop_s || dmack_s) begin
               bst_next = `BST_IDLE; // [RULE17]
            end
         end
         default: bst_next = `BST_IDLE;
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         bst_reg <= `BST_IDLE;
         half_reg <= {`HALF_CNT_W{1'b0}};
      end else if (hw_rst_s || srst_reg) begin
         bst_reg <= `BST_IDLE;
         half_reg <= {`HALF_CNT_W{1'b0}};
      end else begin
         bst_reg <= bst_next;
         if (!in_burst || half_done) begin
            half_reg <= {`HALF_CNT_W{1'b0}};
         end else begin
            half_reg <= half_reg + 1'b1;
         end
      end
   end

   // Sideband activity phase counter
   reg [31:0] phase_reg;
   wire presence_phase = (phase_reg != PRESENCE_CYCLES);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_reg <= 32'h0;
      end else if (hw_rst_s) begin
         phase_reg <= 32'h0;
      end else if (presence_phase) begin
         phase_reg <= phase_reg + 32'h1;
      end
   end

   // Output flops
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         dd_out <= `WORD_RST;
         dd_oe_n <= 1'b1;
         intrq_out <= 1'b0;
         intrq_oe_n <= 1'b1;
         dmarq <= 1'b0;
         ddmardy_n <= 1'b1;
         dstrobe <= 1'b0;
         pdiag_out <= 1'b1;
         pdiag_oe_n <= 1'b1;
         dasp_out <= 1'b1;
         dasp_oe_n <= 1'b1;
         acc_addr <= `ADDR_RST;
         rd_pulse <= 1'b0;
         wr_pulse <= 1'b0;
         wr_data <= `WORD_RST;
         soft_reset <= 1'b0;
         is_slave <= 1'b0;
         cable_80 <= 1'b0;
         slave_passed <= 1'b0;
         tx_take <= 1'b0;
         rx_data <= `WORD_RST;
         rx_valid <= 1'b0;
         burst_end <= 1'b0;
      end else begin
         if (in_step) begin
            dd_out <= tx_data;
         end else if (!in_burst) begin
            dd_out <= rd_data;
         end
         dd_oe_n <= ~((~dior_s & pio_ok) | in_burst); // [RULE21] [RULE1]
         intrq_out <= pend_reg & ~int_clr;
         intrq_oe_n <= ~(selected & ~nien_reg); // [RULE9]
         if (bst_reg == `BST_IDLE && !dmack_s) begin
            dmarq <= 1'b0; // [RULE20]
         end else if (bst_reg == `BST_IDLE) begin
            dmarq <= dma_ready & ~hw_rst_s & ~srst_reg; // [RULE20]
         end else begin
            dmarq <= 1'b0;
         end
         ddmardy_n <= ~(out_burst & rx_ready & ~stop_s); // [RULE19]
         if (in_step) begin
            dstrobe <= ~dstrobe; // [RULE18]
         end else if (bst_reg == `BST_IDLE) begin
            dstrobe <= 1'b0;
         end
         tx_take <= in_step;
         rx_valid <= out_burst & hs_edge; // [RULE4] [RULE5]
         if (out_burst && hs_edge) begin
            rx_data <= d2_reg; // [RULE4]
         end
         burst_end <= (bst_reg != `BST_IDLE) & (bst_next == `BST_IDLE); // [RULE17]
         pdiag_out <= 1'b0;
         pdiag_oe_n <= ~(csel_s & diag_done & ~hw_rst_s); // [RULE13] [RULE14]
         slave_passed <= ~csel_s & ~sb2_reg[1]; // [RULE13]
         cable_80 <= ~sb2_reg[0]; // [RULE15]
         dasp_out <= 1'b0;
         if (presence_phase) begin
            dasp_oe_n <= ~csel_s; // [RULE16]
         end else begin
            dasp_oe_n <= ~drive_active; // [RULE16]
         end
         acc_addr <= dec_s[3:0];
         rd_pulse <= rd_evt;
         wr_pulse <= wr_evt;
         if (wr_evt) begin
            wr_data <= d2_reg;
         end
         soft_reset <= srst_reg | hw_rst_s;
         is_slave <= csel_s;
      end
   end

endmodule // ata_device_host_signals

/* tb/ata_dev_checker_properties.sv */
/* Checker for the device port: interrupt clears, burst pacing, sideband.
   Bound to the top module; sees its ports only. */
module ata_dev_checker (
   input wire clk, rst, dmack_n, hdmardy_n, cblid_in, irq_set, sector_done, diag_done,
   input wire tx_take, dstrobe, rd_pulse, wr_pulse, intrq_out, dmarq, cable_80,
   input wire is_slave, pdiag_oe_n, soft_reset,
   input wire [3:0] acc_addr
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_stat_rd; !irq_set ##1 rd_pulse && acc_addr == 4'h7; endsequence
   sequence s_cmd_wr; !irq_set ##1 wr_pulse && acc_addr == 4'h7; endsequence
   sequence s_sect; sector_done && !irq_set ##1 !irq_set; endsequence
   stat_read_clear_a: assert property (s_stat_rd |=> !intrq_out)
      else $error("intrq high after status read");
   cmd_write_clear_a: assert property (s_cmd_wr |=> !intrq_out)
      else $error("intrq high after command write");
   sector_clear_a: assert property (s_sect |=> !intrq_out)
      else $error("intrq high after sector done");
   reset_clear_a: assert property (soft_reset ##1 soft_reset |-> !intrq_out)
      else $error("intrq high in reset");
   strobe_take_a: assert property (tx_take |-> $changed(dstrobe))
      else $error("word sent without strobe edge");
   take_spacing_a: assert property (tx_take |=> !tx_take [*5])
      else $error("data-in words too close");
   host_pause_a: assert property (hdmardy_n [*5] |-> !tx_take)
      else $error("word sent while host paused");
   dmarq_drop_a: assert property ($fell(dmack_n) |-> ##[1:5] !dmarq)
      else $error("dmarq held after acknowledge");
   cable_type_a: assert property ($stable(cblid_in) [*6] |-> cable_80 == !cblid_in)
      else $error("cable type wrong");
   master_input_a: assert property (!is_slave |-> pdiag_oe_n)
      else $error("master drives diagnostics line");
   slave_passed_a: assert property (diag_done [*3] ##0 is_slave && !soft_reset |-> !pdiag_oe_n)
      else $error("slave silent after diagnostics");
endmodule // ata_dev_checker
bind ata_device_host_signals ata_dev_checker i_chk (.clk, .rst, .dmack_n, .hdmardy_n,
   .cblid_in, .irq_set, .sector_done, .diag_done, .tx_take, .dstrobe, .rd_pulse, .wr_pulse,
   .intrq_out, .dmarq, .cable_80, .is_slave, .pdiag_oe_n, .soft_reset, .acc_addr);

/* tb/host_adapter_model.sv */
/* Host adapter model: register cycles and double-edge data-out strobing.
   Assumes the bench resolves the shared data bus into bus. */
module host_adapter_model (
   input wire logic clk,
   output logic cs0_n, cs1_n, dior_n, diow_n, hstrobe, hdd_oe,
   output logic [2:0] da,
   output logic [15:0] hdd,
   input wire logic [15:0] bus
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {cs0_n, cs1_n, dior_n, diow_n} = 4'hf;
      {hstrobe, hdd_oe} = 2'b10;
      da = 3'h0;
      hdd = 16'h0;
   end
   task automatic acc(input logic blk, input logic [2:0] a, input logic wr,
                      input logic [15:0] d, output logic [15:0] q);
      @(posedge clk) #1;
      cs0_n = blk;
      cs1_n = !blk;
      da = a;
      hdd = d;
      hdd_oe = wr;
      repeat (2) @(posedge clk);
      #1 if (wr) diow_n = 0; else dior_n = 0;
      repeat (13) @(posedge clk);
      #1 q = bus;
      {dior_n, diow_n} = 2'b11;
      repeat (4) @(posedge clk);
      #1 {cs0_n, cs1_n, hdd_oe} = 3'b110;
   endtask
   // Strobe stands still between calls
   task automatic strobe(input int n, input logic [15:0] base);
      @(posedge clk) #1;
      hdd_oe = 1;
      for (int i = 0; i < n; i++) begin
         hdd = base + 16'(i);
         #16 hstrobe = ~hstrobe;
         #16;
      end
      hdd_oe = 0;
   endtask
endmodule // host_adapter_model

/* tb/tb.sv */
/* Bench for the device port: register cycles, interrupt, both bursts, sideband.
   Host adapter model drives strobes; bench drives the user side. */
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, reset_n, csel_n, dmack_n, stop, hdmardy_n, cblid_in, irq_set, sector_done;
   logic diag_done, drive_active, dma_ready, dma_dir_in, tx_valid, rx_ready, pdiag_in;
   logic cs0_n, cs1_n, dior_n, diow_n, hstrobe, hdd_oe, dd_oe_n, intrq_out, intrq_oe_n, dmarq;
   logic ddmardy_n, dstrobe, pdiag_out, pdiag_oe_n, dasp_out, dasp_oe_n, rd_pulse, wr_pulse;
   logic soft_reset, is_slave, cable_80, slave_passed, tx_take, rx_valid, burst_end;
   logic peer_pdiag_n;
   logic [2:0] da;
   logic [3:0] acc_addr;
   logic [15:0] dd_in, hdd, rd_data, tx_data, dd_out, wr_data, rx_data, q, rx_last;
   int mismatches = 0, checks_done = 0, rx_cnt = 0;
   assign dd_in = !dd_oe_n ? dd_out : hdd_oe ? hdd : ~dd_out;
   assign pdiag_in = pdiag_oe_n ? peer_pdiag_n : pdiag_out;
   ata_device_host_signals #(.PRESENCE_CYCLES(32'd20)) i_ata_device_host_signals (.clk, .rst,
      .reset_n, .csel_n, .cs0_n, .cs1_n, .da, .dior_n, .diow_n, .dmack_n, .stop, .hdmardy_n,
      .hstrobe, .dd_in, .dd_out, .dd_oe_n, .intrq_out, .intrq_oe_n, .dmarq, .ddmardy_n, .dstrobe,
      .pdiag_in, .pdiag_out, .pdiag_oe_n, .cblid_in, .dasp_out, .dasp_oe_n, .rd_data, .acc_addr,
      .rd_pulse, .wr_pulse, .wr_data, .soft_reset, .is_slave, .cable_80, .slave_passed,
      .irq_set, .sector_done, .diag_done, .drive_active, .dma_ready, .dma_dir_in, .tx_data,
      .tx_valid, .tx_take, .rx_data, .rx_valid, .rx_ready, .burst_end);
   host_adapter_model i_host_adapter_model (.clk, .cs0_n, .cs1_n, .dior_n, .diow_n, .hstrobe,
      .hdd_oe, .da, .hdd, .bus(dd_in));
   always @(posedge clk) if (rx_valid) begin
      rx_cnt <= rx_cnt + 1;
      rx_last <= rx_data;
   end
   task automatic tick(input int n); repeat (n) @(posedge clk); #1; endtask
   task automatic chk(input string n, input logic [15:0] e, g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic irq(); irq_set = 1; tick(1); irq_set = 0; tick(3); endtask
   task automatic acc(input logic b, input logic [2:0] a, input logic w, input logic [15:0] d);
      i_host_adapter_model.acc(b, a, w, d, q);
   endtask
   task automatic wait_end();
      int k;
      k = 0;
      repeat (12) begin tick(1); if (burst_end) k = 1; end
      chk("burst_end", 1, k[15:0]);
   endtask
   task automatic t_reg();
      irq();
      chk("intrq_oe_n", 0, intrq_oe_n);
      acc(0, 3'h7, 0, 0);
      chk("rd_word", rd_data, q);
      chk("acc_addr", 16'h7, acc_addr);
      chk("intrq_out", 0, intrq_out);
      chk("dd_oe_n", 1, dd_oe_n);
      irq();
      acc(0, 3'h7, 1, 16'h00c8);
      chk("wr_data", 16'h00c8, wr_data);
      chk("intrq_out", 0, intrq_out);
   endtask
   task automatic t_ctrl();
      acc(1, 3'h6, 1, 16'h0002);
      chk("acc_addr", 16'he, acc_addr);
      chk("intrq_oe_n", 1, intrq_oe_n);
      irq();
      acc(1, 3'h6, 1, 16'h0004);
      chk("soft_reset", 1, soft_reset);
      chk("intrq_out", 0, intrq_out);
      acc(1, 3'h6, 1, 16'h0000);
      acc(0, 3'h6, 1, 16'h0010);
      chk("intrq_oe_n", 1, intrq_oe_n);
      acc(0, 3'h6, 1, 16'h0000);
      irq();
      reset_n = 0;
      tick(4);
      chk("intrq_out", 0, intrq_out);
      reset_n = 1;
      tick(4);
   endtask
   task automatic t_sector();
      irq();
      chk("intrq_out", 1, intrq_out);
      sector_done = 1;
      tick(1);
      sector_done = 0;
      tick(2);
      chk("intrq_out", 0, intrq_out);
   endtask
   task automatic t_dma_in();
      int n;
      {dma_dir_in, tx_valid, dma_ready} = 3'b111;
      tick(3);
      chk("dmarq", 1, dmarq);
      dmack_n = 0;
      hdmardy_n = 0;
      tick(5);
      chk("dmarq", 0, dmarq);
      n = 0;
      repeat (36) begin tick(1); n += tx_take; end
      chk("takes", 6, n[15:0]);
      chk("dd_out", tx_data, dd_out);
      chk("dd_oe_n", 0, dd_oe_n);
      hdmardy_n = 1;
      tick(4);
      n = 0;
      repeat (30) begin tick(1); n += tx_take; end
      chk("paused", 0, n[15:0]);
      stop = 1;
      wait_end();
      {stop, dmack_n, dma_ready} = 3'b010;
      tick(4);
   endtask
   task automatic t_dma_out();
      int c0;
      {dma_dir_in, dma_ready, rx_ready} = 3'b011;
      tick(3);
      dmack_n = 0;
      tick(6);
      chk("ddmardy_n", 0, ddmardy_n);
      c0 = rx_cnt;
      i_host_adapter_model.strobe(4, 16'h1230);
      tick(8);
      chk("rx_cnt", 4, 16'(rx_cnt - c0));
      chk("rx_last", 16'h1233, rx_last);
      tick(40);
      chk("rx_cnt", 4, 16'(rx_cnt - c0));
      chk("ddmardy_n", 0, ddmardy_n);
      rx_ready = 0;
      tick(4);
      chk("ddmardy_n", 1, ddmardy_n);
      stop = 1;
      wait_end();
      {stop, dmack_n, dma_ready} = 3'b010;
      tick(4);
   endtask
   task automatic t_side();
      cblid_in = 0;
      tick(5);
      chk("cable_80", 1, cable_80);
      cblid_in = 1;
      diag_done = 1;
      peer_pdiag_n = 0;
      tick(5);
      chk("cable_80", 0, cable_80);
      chk("pdiag_oe_n", 1, pdiag_oe_n);
      chk("slave_passed", 1, slave_passed);
      peer_pdiag_n = 1;
      csel_n = 1;
      tick(6);
      chk("pdiag_oe_n", 0, pdiag_oe_n);
      chk("is_slave", 1, is_slave);
      chk("slave_passed", 0, slave_passed);
      chk("dasp_oe_n", 1, dasp_oe_n);
      drive_active = 1;
      tick(3);
      chk("dasp_oe_n", 0, dasp_oe_n);
      drive_active = 0;
      reset_n = 0;
      tick(4);
      reset_n = 1;
      tick(6);
      chk("dasp_oe_n", 0, dasp_oe_n);
      tick(25);
      chk("dasp_oe_n", 1, dasp_oe_n);
   endtask
   task automatic tally_and_finish();
      if (mismatches == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      {rst, reset_n, csel_n, dmack_n, stop, hdmardy_n, cblid_in} = 7'b1101011;
      {irq_set, sector_done, diag_done, drive_active, dma_ready, dma_dir_in} = 6'h0;
      {tx_valid, rx_ready, peer_pdiag_n} = 3'b001;
      rd_data = 16'h5a3c;
      tx_data = 16'hbeef;
      repeat (12) @(posedge clk);
      #1 rst = 0;
      tick(4);
      t_reg();
      t_ctrl();
      t_sector();
      t_dma_in();
      t_dma_out();
      t_side();
      tally_and_finish();
   end
   initial begin
      #100us;
      mismatches++;
      tally_and_finish();
   end
endmodule // tb
